// >>> cmp_regs_pkg.sv
package cmp_regs_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_AB_CONFIG = 16'ha038;
	localparam logic [15:0] IDX_CD_CONFIG = 16'ha039;
	localparam logic [15:0] IDX_THRESHOLD = 16'ha03a;
	localparam logic [15:0] IDX_EVENT_FLAGS = 16'ha040;
	localparam logic [15:0] IDX_EVENT_MASK = 16'ha041;
	localparam logic [15:0] IDX_LIVE_STATE = 16'ha042;

	localparam int ADR_W = 18;
	localparam logic [17:0] ADR_AB_CONFIG = {IDX_AB_CONFIG, 2'b00};
	localparam logic [17:0] ADR_CD_CONFIG = {IDX_CD_CONFIG, 2'b00};
	localparam logic [17:0] ADR_THRESHOLD = {IDX_THRESHOLD, 2'b00};
	localparam logic [17:0] ADR_EVENT_FLAGS = {IDX_EVENT_FLAGS, 2'b00};
	localparam logic [17:0] ADR_EVENT_MASK = {IDX_EVENT_MASK, 2'b00};
	localparam logic [17:0] ADR_LIVE_STATE = {IDX_LIVE_STATE, 2'b00};

	// channel order inside the vectors: 0 = A, 1 = B, 2 = C, 3 = D
	localparam int NUM_CH = 4;
	localparam int CH_A = 0;
	localparam int CH_B = 1;
	localparam int CH_C = 2;
	localparam int CH_D = 3;

	// field positions inside one channel nibble
	localparam int FLD_ON = 3;
	localparam int FLD_REF_SEL = 2;
	localparam int FLD_IRQ_ON = 1;
	localparam int FLD_INVERT = 0;
	// nibble positions inside a configuration byte
	localparam int NIB_FIRST = 4;
	localparam int NIB_SECOND = 0;

	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_THRESHOLD = 8'h00;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic [3:0] RST_MASK = 4'h0;

	// dac code 8'h00 is 0 mV, 8'hff is full scale
	localparam int DAC_FULL_SCALE_MV = 1500;

	// analog bias settling after enable
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETTLE_NS = 20000;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 10;

	typedef struct packed {
		logic on;
		logic ref_sel;
		logic irq_on;
		logic invert;
	} cmp_chan_s;

endpackage : cmp_regs_pkg

// >>> comparator_cd_config_regs.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module comparator_cd_config_regs (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [cmp_regs_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// analog comparators
	input wire logic [cmp_regs_pkg::NUM_CH-1:0] cmp_raw,
	output cmp_regs_pkg::cmp_chan_s [cmp_regs_pkg::NUM_CH-1:0] chan_cfg,
	output logic [7:0] internal_ref_level,
	output logic [cmp_regs_pkg::NUM_CH-1:0] cmp_live_out,
	// interrupts
	output logic [cmp_regs_pkg::NUM_CH-1:0] irq_req,
	output logic irq
);

	localparam int N = cmp_regs_pkg::NUM_CH;

	logic [7:0] ab_config;
	logic [7:0] cd_config;
	logic [7:0] threshold;
	logic [N-1:0] event_flag;
	logic [N-1:0] event_mask;
	logic [31:0] rd_data;
	logic [7:0] next_ab_config;
	logic [7:0] next_cd_config;
	logic [7:0] next_threshold;
	logic [N-1:0] next_event_flag;
	logic [N-1:0] next_event_mask;
	logic next_ack;
	logic [31:0] next_rd_data;
	logic bus_req;
	logic do_write;
	logic wr_ab;
	logic wr_cd;
	logic wr_thr;
	logic wr_flags;
	logic wr_mask;

	logic [N-1:0] sync1;
	logic [N-1:0] sync2;
	logic [N-1:0] sync3;
	logic [N-1:0] seen;
	logic [N-1:0] next_seen;
	logic [N-1:0] prev_live;
	logic [N-1:0] prev_on;
	logic [N-1:0] toggle;
	logic [N-1:0] settled;
	logic [N-1:0] live;

	// write takes effect at the edge where the master samples ack
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign do_write = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign wr_ab = do_write && (wb_adr_i == cmp_regs_pkg::ADR_AB_CONFIG);
	assign wr_cd = do_write && (wb_adr_i == cmp_regs_pkg::ADR_CD_CONFIG);
	assign wr_thr = do_write && (wb_adr_i == cmp_regs_pkg::ADR_THRESHOLD);
	assign wr_flags = do_write && (wb_adr_i == cmp_regs_pkg::ADR_EVENT_FLAGS);
	assign wr_mask = do_write && (wb_adr_i == cmp_regs_pkg::ADR_EVENT_MASK);

	// channel view of the two configuration bytes
	assign chan_cfg[cmp_regs_pkg::CH_A] = ab_config[cmp_regs_pkg::NIB_FIRST +: 4];
	assign chan_cfg[cmp_regs_pkg::CH_B] = ab_config[cmp_regs_pkg::NIB_SECOND +: 4];
	assign chan_cfg[cmp_regs_pkg::CH_C] = cd_config[cmp_regs_pkg::NIB_FIRST +: 4];
	assign chan_cfg[cmp_regs_pkg::CH_D] = cd_config[cmp_regs_pkg::NIB_SECOND +: 4];
	assign internal_ref_level = threshold;

	always_comb
	begin
		next_ab_config = ab_config;
		next_cd_config = cd_config;
		next_threshold = threshold;
		next_event_mask = event_mask;
		next_ack = bus_req & ~wb_ack_o;
		next_rd_data = rd_data;
		if (wr_ab)
			next_ab_config = wb_dat_i[7:0];
		if (wr_cd)
			next_cd_config = wb_dat_i[7:0];
		if (wr_thr)
			next_threshold = wb_dat_i[7:0];
		if (wr_mask)
			next_event_mask = wb_dat_i[N-1:0];
		// set wins over a write-one clear in the same cycle
		next_event_flag = (event_flag & ~(wr_flags ? wb_dat_i[N-1:0] : '0)) | toggle;
		if (bus_req && !wb_ack_o)
		begin
			if (wb_adr_i == cmp_regs_pkg::ADR_AB_CONFIG)
				next_rd_data = {24'h00_0000, ab_config};
			else if (wb_adr_i == cmp_regs_pkg::ADR_CD_CONFIG)
				next_rd_data = {24'h00_0000, cd_config};
			else if (wb_adr_i == cmp_regs_pkg::ADR_THRESHOLD)
				next_rd_data = {24'h00_0000, threshold};
			else if (wb_adr_i == cmp_regs_pkg::ADR_EVENT_FLAGS)
				next_rd_data = {28'h000_0000, event_flag};
			else if (wb_adr_i == cmp_regs_pkg::ADR_EVENT_MASK)
				next_rd_data = {28'h000_0000, event_mask};
			else if (wb_adr_i == cmp_regs_pkg::ADR_LIVE_STATE)
				next_rd_data = {24'h00_0000, settled, live};
			else
				next_rd_data = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ab_config <= cmp_regs_pkg::RST_CONFIG;
			cd_config <= cmp_regs_pkg::RST_CONFIG;
			threshold <= cmp_regs_pkg::RST_THRESHOLD;
			event_flag <= cmp_regs_pkg::RST_FLAGS;
			event_mask <= cmp_regs_pkg::RST_MASK;
			wb_ack_o <= 1'b0;
			rd_data <= 32'h0000_0000;
		end
		else
		begin
			ab_config <= next_ab_config;
			cd_config <= next_cd_config;
			threshold <= next_threshold;
			event_flag <= next_event_flag;
			event_mask <= next_event_mask;
			wb_ack_o <= next_ack;
			rd_data <= next_rd_data;
		end
	end

	assign wb_dat_o = rd_data;

	// comparator outputs are asynchronous: three stages, accept when the last two agree
	always_comb
	begin
		next_seen = seen;
		for (int i = 0; i < N; i++)
		begin
			if (sync2[i] == sync3[i])
				next_seen[i] = sync3[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			seen <= '0;
			prev_live <= '0;
			prev_on <= '0;
		end
		else
		begin
			sync1 <= cmp_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			seen <= next_seen;
			prev_live <= live;
			for (int i = 0; i < N; i++)
				prev_on[i] <= chan_cfg[i].on;
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_chan
			logic [cmp_regs_pkg::SETTLE_W-1:0] settle_cnt;
			logic [cmp_regs_pkg::SETTLE_W-1:0] next_settle_cnt;

			// disabled channel reads low; polarity applied after the synchroniser
			assign live[g] = chan_cfg[g].on & (seen[g] ^ chan_cfg[g].invert);
			// any edge while enabled in both cycles is an event
			assign toggle[g] = chan_cfg[g].on & prev_on[g] & (live[g] ^ prev_live[g]);
			assign irq_req[g] = event_flag[g] & chan_cfg[g].irq_on;
			// status hint that bias has had time to settle
			assign settled[g] = (settle_cnt == cmp_regs_pkg::SETTLE_W'(cmp_regs_pkg::SETTLE_CYCLES));

			always_comb
			begin
				next_settle_cnt = settle_cnt;
				if (!chan_cfg[g].on)
					next_settle_cnt = '0;
				else if (!settled[g])
					next_settle_cnt = settle_cnt + 1'b1;
			end

			always_ff @(posedge clk)
			begin
				if (sys_rst)
					settle_cnt <= '0;
				else
					settle_cnt <= next_settle_cnt;
			end
		end
	endgenerate

	assign cmp_live_out = live;
	assign irq = |(irq_req & event_mask);

	chk_d_power_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_cd |=> chan_cfg[cmp_regs_pkg::CH_D].on == $past(wb_dat_i[3]))
		else $error("channel D enable does not follow the write");

	chk_c_ref_select: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_cd |=> chan_cfg[cmp_regs_pkg::CH_C].ref_sel == $past(wb_dat_i[6]))
		else $error("channel C threshold select wrong");

	chk_d_ref_select: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_cd |=> chan_cfg[cmp_regs_pkg::CH_D].ref_sel == $past(wb_dat_i[2]))
		else $error("channel D threshold select wrong");

	chk_c_irq_blocked: assert property (
		@(posedge clk) disable iff (sys_rst)
		!chan_cfg[cmp_regs_pkg::CH_C].irq_on |-> !irq_req[cmp_regs_pkg::CH_C])
		else $error("channel C request while its enable is clear");

	chk_d_irq_raised: assert property (
		@(posedge clk) disable iff (sys_rst)
		event_flag[cmp_regs_pkg::CH_D] && chan_cfg[cmp_regs_pkg::CH_D].irq_on
			|-> irq_req[cmp_regs_pkg::CH_D])
		else $error("channel D request missing");

	chk_c_polarity_sense: assert property (
		@(posedge clk) disable iff (sys_rst)
		chan_cfg[cmp_regs_pkg::CH_C].on && !chan_cfg[cmp_regs_pkg::CH_C].invert
			|-> cmp_live_out[cmp_regs_pkg::CH_C] == seen[cmp_regs_pkg::CH_C])
		else $error("channel C default sense wrong");

	chk_d_polarity_invert: assert property (
		@(posedge clk) disable iff (sys_rst)
		chan_cfg[cmp_regs_pkg::CH_D].on && chan_cfg[cmp_regs_pkg::CH_D].invert
			|-> cmp_live_out[cmp_regs_pkg::CH_D] != seen[cmp_regs_pkg::CH_D])
		else $error("channel D inverted sense wrong");

	chk_dac_code_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_thr |=> internal_ref_level == $past(wb_dat_i[7:0]))
		else $error("dac code does not follow the write");

	chk_cd_reset_zero: assert property (
		@(posedge clk)
		sys_rst |=> cd_config == cmp_regs_pkg::RST_CONFIG
			&& ab_config == cmp_regs_pkg::RST_CONFIG)
		else $error("configuration not zero after reset");

	chk_ab_separate: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_cd |=> $stable(ab_config))
		else $error("A/B configuration disturbed by a C/D write");

	chk_edge_sets_flag: assert property (
		@(posedge clk) disable iff (sys_rst)
		toggle[cmp_regs_pkg::CH_C] |=> event_flag[cmp_regs_pkg::CH_C])
		else $error("channel C edge did not set its flag");

	chk_flag_holds: assert property (
		@(posedge clk) disable iff (sys_rst)
		event_flag[cmp_regs_pkg::CH_D] && !(wr_flags && wb_dat_i[cmp_regs_pkg::CH_D])
			|=> event_flag[cmp_regs_pkg::CH_D])
		else $error("channel D flag dropped without a clear");

	chk_ack_one_cycle: assert property (
		@(posedge clk) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	chk_irq_unmasked_c: assert property (
		@(posedge clk) disable iff (sys_rst)
		event_flag[cmp_regs_pkg::CH_C] && chan_cfg[cmp_regs_pkg::CH_C].irq_on
			&& event_mask[cmp_regs_pkg::CH_C] |-> irq)
		else $error("channel C request did not reach the interrupt line");

	chk_d_toggle_flag: assert property (
		@(posedge clk) disable iff (sys_rst)
		chan_cfg[cmp_regs_pkg::CH_D].on && $past(chan_cfg[cmp_regs_pkg::CH_D].on)
			&& $changed(cmp_live_out[cmp_regs_pkg::CH_D]) |=> event_flag[cmp_regs_pkg::CH_D])
		else $error("channel D edge did not set its flag");

	chk_d_off_low: assert property (
		@(posedge clk) disable iff (sys_rst)
		!chan_cfg[cmp_regs_pkg::CH_D].on |-> !cmp_live_out[cmp_regs_pkg::CH_D])
		else $error("disabled channel D output not low");

	chk_cd_write_back: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_cd |=> cd_config == $past(wb_dat_i[7:0]))
		else $error("C/D configuration does not hold the written byte");

	chk_ab_write_back: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_ab |=> ab_config == $past(wb_dat_i[7:0]))
		else $error("A/B configuration does not hold the written byte");

	chk_c_off_quiet: assert property (
		@(posedge clk) disable iff (sys_rst)
		!chan_cfg[cmp_regs_pkg::CH_C].on && !event_flag[cmp_regs_pkg::CH_C]
			|=> !event_flag[cmp_regs_pkg::CH_C])
		else $error("channel C flag set while disabled");

	chk_d_flag_clear: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_flags && wb_dat_i[cmp_regs_pkg::CH_D] && !toggle[cmp_regs_pkg::CH_D]
			|=> !event_flag[cmp_regs_pkg::CH_D])
		else $error("channel D flag not cleared by a write of one");

	chk_d_irq_blocked: assert property (
		@(posedge clk) disable iff (sys_rst)
		!chan_cfg[cmp_regs_pkg::CH_D].irq_on |-> !irq_req[cmp_regs_pkg::CH_D])
		else $error("channel D request while its enable is clear");

	cov_cd_write: cover property (@(posedge clk) disable iff (sys_rst) wr_cd);
	cov_d_event: cover property (@(posedge clk) disable iff (sys_rst) toggle[cmp_regs_pkg::CH_D]);
	cov_irq_rise: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
	cov_settled: cover property (@(posedge clk) disable iff (sys_rst)
		$rose(settled[cmp_regs_pkg::CH_D]));
	cov_d_irq: cover property (@(posedge clk) disable iff (sys_rst) irq_req[cmp_regs_pkg::CH_D]);

endmodule : comparator_cd_config_regs

`default_nettype wire

// >>> comparator_cd_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module comparator_cd_config_regs_test;
	logic clk, sys_rst, cyc, stb, we;
	logic [17:0] adr;
	logic [3:0] sel, raw;
	logic [31:0] wdat, rdat, dat_o;
	logic ack, irq;
	logic [7:0] ref_level;
	logic [3:0] live, irq_req;
	cmp_regs_pkg::cmp_chan_s [3:0] cfg;
	int n_fail = 0;
	int comparisons = 0;

	comparator_cd_config_regs dut (
		.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.cmp_raw(raw), .chan_cfg(cfg), .internal_ref_level(ref_level),
		.cmp_live_out(live), .irq_req(irq_req), .irq(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one classic cycle; held until ack is sampled high, then released
	task automatic wb_cycle(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= {24'h00_0000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
		begin
			n_fail++;
			conclude();
		end
		// idle edge: the master stays low and the written value has settled
		@(posedge clk);
	endtask : wb_cycle

	task automatic rd_chk(input logic [17:0] a, input logic [7:0] exp);
		wb_cycle(1'b0, a, 8'h00);
		chk(rdat, {24'h00_0000, exp});
	endtask : rd_chk

	task automatic wait_live(input int ch, input logic v);
		int n;
		n = 0;
		while (live[ch] !== v && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		chk({31'h0000_0000, live[ch]}, {31'h0000_0000, v});
		if (live[ch] !== v)
			conclude();
		repeat (3) @(posedge clk);
	endtask : wait_live

	initial
	begin
		sys_rst <= 1'b1;
		{cyc, stb, we} <= 3'b000;
		adr <= '0;
		sel <= 4'h0;
		wdat <= 32'h0000_0000;
		raw <= 4'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(cmp_regs_pkg::ADR_AB_CONFIG, 8'h00);
		rd_chk(cmp_regs_pkg::ADR_CD_CONFIG, 8'h00);
		rd_chk(cmp_regs_pkg::ADR_THRESHOLD, 8'h00);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h00);
		chk(32'(cfg), 32'h0000_0000);
		$display("test reset done");

		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'ha5);
		rd_chk(cmp_regs_pkg::ADR_CD_CONFIG, 8'ha5);
		chk(32'(cfg[cmp_regs_pkg::CH_C]), 32'h0000_000a);
		chk(32'(cfg[cmp_regs_pkg::CH_D]), 32'h0000_0005);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'h5a);
		chk(32'(cfg[cmp_regs_pkg::CH_C]), 32'h0000_0005);
		chk(32'(cfg[cmp_regs_pkg::CH_D]), 32'h0000_000a);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_AB_CONFIG, 8'h3c);
		rd_chk(cmp_regs_pkg::ADR_AB_CONFIG, 8'h3c);
		chk(32'(cfg[cmp_regs_pkg::CH_A]), 32'h0000_0003);
		chk(32'(cfg[cmp_regs_pkg::CH_B]), 32'h0000_000c);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_AB_CONFIG, 8'h00);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_THRESHOLD, 8'hff);
		rd_chk(cmp_regs_pkg::ADR_THRESHOLD, 8'hff);
		chk({24'h00_0000, ref_level}, 32'h0000_00ff);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_THRESHOLD, 8'h00);
		chk({24'h00_0000, ref_level}, 32'h0000_0000);
		rd_chk(18'h0_0100, 8'h00);
		$display("test registers done");

		wb_cycle(1'b1, cmp_regs_pkg::ADR_EVENT_MASK, 8'h0c);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'ha8);
		repeat (cmp_regs_pkg::SETTLE_CYCLES) @(posedge clk);
		raw[2] <= 1'b1;
		wait_live(2, 1'b1);
		chk({28'h000_0000, irq_req}, 32'h0000_0004);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h04);
		raw[3] <= 1'b1;
		wait_live(3, 1'b1);
		chk({28'h000_0000, irq_req}, 32'h0000_0004);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h0c);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h0c);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h00);
		chk({27'h000_0000, irq_req, irq}, 32'h0000_0000);
		$display("test events done");

		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'ha9);
		wait_live(3, 1'b0);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h08);
		chk({27'h000_0000, irq_req, irq}, 32'h0000_0000);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_EVENT_MASK, 8'h00);
		raw[2] <= 1'b0;
		wait_live(2, 1'b0);
		chk({27'h000_0000, irq_req, irq}, 32'h0000_0008);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h0c);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'h29);
		raw[2] <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0000_0000, live[2]}, 32'h0000_0000);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h00);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'h00);
		raw[3] <= 1'b0;
		repeat (8) @(posedge clk);
		chk({28'h000_0000, live}, 32'h0000_0000);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h00);
		$display("test polarity and disable done");

		wb_cycle(1'b1, cmp_regs_pkg::ADR_EVENT_MASK, 8'h08);
		wb_cycle(1'b1, cmp_regs_pkg::ADR_CD_CONFIG, 8'h0a);
		rd_chk(cmp_regs_pkg::ADR_LIVE_STATE, 8'h00);
		repeat (cmp_regs_pkg::SETTLE_CYCLES) @(posedge clk);
		rd_chk(cmp_regs_pkg::ADR_LIVE_STATE, 8'h80);
		raw[3] <= 1'b1;
		wait_live(3, 1'b1);
		chk({27'h000_0000, irq_req, irq}, 32'h0000_0011);
		rd_chk(cmp_regs_pkg::ADR_LIVE_STATE, 8'h88);
		rd_chk(cmp_regs_pkg::ADR_EVENT_FLAGS, 8'h08);
		$display("test interrupt raise done");
		conclude();
	end
endmodule : comparator_cd_config_regs_test

`default_nettype wire
